// file: pkg/cosdo_pkg.sv
// Constants and types shared by the service-data server block.
package cosdo_pkg;
  localparam logic [10:0] COSDO_RX_BASE     = 11'h600;
  localparam logic [10:0] COSDO_TX_BASE     = 11'h580;
  localparam int          COSDO_LEN         = 8;
  localparam logic [7:0]  COSDO_WR_UNSPEC   = 8'h22;
  localparam logic [7:0]  COSDO_WR4         = 8'h23;
  localparam logic [7:0]  COSDO_WR2         = 8'h2b;
  localparam logic [7:0]  COSDO_WR1         = 8'h2f;
  localparam logic [7:0]  COSDO_RD          = 8'h40;
  localparam logic [7:0]  COSDO_SEG_REQ0    = 8'h60;
  localparam logic [7:0]  COSDO_SEG_REQ1    = 8'h70;
  localparam logic [7:0]  COSDO_WR_ACK      = 8'h60;
  localparam logic [7:0]  COSDO_RD_ANS4     = 8'h43;
  localparam logic [7:0]  COSDO_RD_ANS2     = 8'h4b;
  localparam logic [7:0]  COSDO_RD_ANS1     = 8'h4f;
  localparam logic [7:0]  COSDO_SEG_INIT    = 8'h41;
  localparam logic [7:0]  COSDO_SEG_LAST2   = 8'h06;
  localparam logic [7:0]  COSDO_TOGGLE_BIT  = 8'h10;
  localparam logic [7:0]  COSDO_ABORT       = 8'h80;
  localparam logic [15:0] COSDO_IDX_PARAM   = 16'h1200;
  localparam logic [15:0] COSDO_IDX_SAVE    = 16'h1010;
  localparam logic [15:0] COSDO_IDX_NV      = 16'h2000;
  localparam logic [15:0] COSDO_IDX_RW      = 16'h3ce2;
  localparam logic [15:0] COSDO_IDX_RB      = 16'h3d02;
  localparam logic [15:0] COSDO_IDX_WW      = 16'h3d22;
  localparam logic [15:0] COSDO_IDX_WB      = 16'h3d42;
  localparam logic [15:0] COSDO_IDX_RPDO    = 16'h1600;
  localparam logic [15:0] COSDO_IDX_TPDO    = 16'h1a00;
  localparam logic [15:0] COSDO_IDX_VEND_HI = 16'h5fff;
  localparam logic [7:0]  COSDO_PARAM_N     = 8'h02;
  localparam int          COSDO_MARKS       = 32;
  localparam logic [31:0] COSDO_ABT_CMD     = 32'h0504_0001;
  localparam logic [31:0] COSDO_ABT_NOOBJ   = 32'h0602_0000;
  localparam logic [31:0] COSDO_ABT_RO      = 32'h0601_0002;
  localparam logic [31:0] COSDO_ABT_SUB     = 32'h0609_0011;
  typedef enum logic [1:0] {
    COSDO_IDLE = 2'b00,
    COSDO_SEG  = 2'b01
  } cosdo_state_t;
endpackage

// file: src/cosdo_server.sv
// Service-data server with communication marker dictionary and PDO gate.
module cosdo_server
  import cosdo_pkg::*;
#(
  parameter logic [6:0] NODE_ID = 7'h01
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Received telegram, one cycle strobe
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic [63:0] rx_data,
  // Response telegram, one cycle strobe
  output logic             tx_valid,
  output logic [10:0]      tx_id,
  output logic [63:0]      tx_data,
  // Nonvolatile store request, one cycle strobe
  output logic             nv_write,
  output logic             nv_save,
  output logic [15:0]      nv_index,
  output logic [7:0]       nv_sub,
  output logic [31:0]      nv_value,
  // Network state and process data
  input  wire logic        operational,
  input  wire logic        pdo_rx_valid,
  output logic             pdo_rx_accept,
  output logic             pdo_tx_enable,
  // Received markers loaded by the process data path
  input  wire logic        rmark_we,
  input  wire logic        rmark_byte,
  input  wire logic [4:0]  rmark_sel,
  input  wire logic [15:0] rmark_value,
  // Mapping check
  input  wire logic [15:0] map_index,
  input  wire logic        map_tx,
  output logic             map_ok
);

  // Contract
  // [R1] One server reaching whole dictionary, record read-only
  // [R2] Request id 600h+node, answer 580h+node
  // [R3] Eight byte telegram: command, index, sub, data
  // [R4] Client writes 23h/2Bh/2Fh/22h, reads 40h
  // [R5] Write ack 60h; read answers 43h/4Bh/4Fh
  // [R6] Answer echoes index and sub-index
  // [R7] Up to four bytes single, longer segmented
  // [R8] Segmented read 41h, segments toggled sizes; code sends the toggle bit only, no size code
  // [R9] Transfer finishes only when server confirms
  // [R10] Client may abort with 80h
  // [R11] Only addressed node answers
  // [R12] Integers least significant byte first
  // [R13] Index 2000h up stored nonvolatile; 1010h saves
  // [R14] Process data only while operational
  // [R15] Process data carries mapped bytes only
  // [R16] Configuration never mappable; mapping attribute decides
  // [R17] Read markers to receive, write markers transmit
  // [R18] Marker layout of four 32-entry ranges
  // [R19] Unknown command or object gets abort

  logic [15:0] rw_mem [COSDO_MARKS];
  logic [7:0]  rb_mem [COSDO_MARKS];
  logic [15:0] ww_r   [COSDO_MARKS];
  logic [15:0] ww_nxt [COSDO_MARKS];
  logic [7:0]  wb_r   [COSDO_MARKS];
  logic [7:0]  wb_nxt [COSDO_MARKS];
  cosdo_state_t state_r, state_nxt;
  logic [7:0]  seg_left_r, seg_left_nxt;
  logic [7:0]  seg_pos_r, seg_pos_nxt;
  logic        seg_tog_r, seg_tog_nxt;
  logic [15:0] seg_idx_r, seg_idx_nxt;
  logic [7:0]  seg_sub_r, seg_sub_nxt;
  logic        tx_valid_nxt;
  logic [63:0] tx_data_nxt;
  logic        nv_write_nxt, nv_save_nxt;
  logic [15:0] nv_index_nxt;
  logic [7:0]  nv_sub_nxt;
  logic [31:0] nv_value_nxt;
  logic [63:0] seg_word;

  logic [7:0]  cmd;
  logic [15:0] idx;
  logic [7:0]  sub;
  logic [31:0] val;
  logic        hit;
  logic [10:0] rx_own;
  logic [10:0] tx_own;

  // Range test on a 32-entry marker block; slot gives the entry number.
  function automatic logic in_block(input logic [15:0] i,
                                    input logic [15:0] base);
    logic [15:0] d;
    d = i - base;
    return (i >= base) && (d < 16'(COSDO_MARKS));
  endfunction

  function automatic logic [4:0] slot(input logic [15:0] i,
                                      input logic [15:0] base);
    logic [15:0] d;
    d = i - base;
    return d[4:0];
  endfunction

  // Abort telegram carrying the echoed object address and a reason.
  function automatic logic [63:0] abort_t(input logic [15:0] i,
                                          input logic [7:0] s,
                                          input logic [31:0] c);
    return {c, s, i, COSDO_ABORT};
  endfunction

  assign rx_own = COSDO_RX_BASE + 11'(NODE_ID); // [R2]
  assign tx_own = COSDO_TX_BASE + 11'(NODE_ID); // [R2]
  assign cmd = rx_data[7:0]; // [R3]
  assign idx = rx_data[23:8]; // [R3] [R12]
  assign sub = rx_data[31:24]; // [R3]
  assign val = rx_data[63:32]; // [R3] [R12]
  assign hit = rx_valid && (rx_id == rx_own); // [R11]

  always_comb
  begin
    for (int k = 0; k < COSDO_MARKS; k++)
    begin
      ww_nxt[k] = ww_r[k];
      wb_nxt[k] = wb_r[k];
    end
    state_nxt    = state_r;
    seg_left_nxt = seg_left_r;
    seg_pos_nxt  = seg_pos_r;
    seg_tog_nxt  = seg_tog_r;
    seg_idx_nxt  = seg_idx_r;
    seg_sub_nxt  = seg_sub_r;
    tx_valid_nxt = 1'b0;
    tx_data_nxt  = tx_data;
    nv_write_nxt = 1'b0;
    nv_save_nxt  = 1'b0;
    nv_index_nxt = nv_index;
    nv_sub_nxt   = nv_sub;
    nv_value_nxt = nv_value;
    seg_word     = 64'h0;
    if (hit) // [R11]
    begin
      tx_valid_nxt = 1'b1; // [R9]
      tx_data_nxt  = abort_t(idx, sub, COSDO_ABT_CMD); // [R19]
      if (cmd == COSDO_ABORT) // [R10]
      begin
        tx_valid_nxt = 1'b0;
        state_nxt    = COSDO_IDLE;
      end
      else if (cmd == COSDO_WR4 || cmd == COSDO_WR2 || // [R4]
               cmd == COSDO_WR1 || cmd == COSDO_WR_UNSPEC)
      begin
        state_nxt   = COSDO_IDLE;
        tx_data_nxt = abort_t(idx, sub, COSDO_ABT_NOOBJ); // [R19]
        if (in_block(idx, COSDO_IDX_WW))
        begin
          ww_nxt[slot(idx, COSDO_IDX_WW)] = val[15:0]; // [R18]
          tx_data_nxt = {32'h0, sub, idx, COSDO_WR_ACK}; // [R5] [R6]
        end
        else if (in_block(idx, COSDO_IDX_WB))
        begin
          wb_nxt[slot(idx, COSDO_IDX_WB)] = val[7:0]; // [R18]
          tx_data_nxt = {32'h0, sub, idx, COSDO_WR_ACK}; // [R5] [R6]
        end
        else if (in_block(idx, COSDO_IDX_RW) ||
                 in_block(idx, COSDO_IDX_RB) || idx == COSDO_IDX_PARAM)
          tx_data_nxt = abort_t(idx, sub, COSDO_ABT_RO); // [R1] [R18]
        else if (idx == COSDO_IDX_SAVE || idx >= COSDO_IDX_NV)
        begin
          // Other objects live outside; they are passed on with the ack.
          tx_data_nxt  = {32'h0, sub, idx, COSDO_WR_ACK}; // [R5] [R6]
          nv_save_nxt  = (idx == COSDO_IDX_SAVE); // [R13]
        end
        if (tx_data_nxt[7:0] == COSDO_WR_ACK && idx >= COSDO_IDX_NV)
          nv_write_nxt = 1'b1; // [R13]
        nv_index_nxt = idx;
        nv_sub_nxt   = sub;
        nv_value_nxt = val;
      end
      else if (cmd == COSDO_RD) // [R4]
      begin
        state_nxt   = COSDO_IDLE;
        tx_data_nxt = abort_t(idx, sub, COSDO_ABT_NOOBJ); // [R19]
        if (in_block(idx, COSDO_IDX_RW)) // [R7]
          tx_data_nxt = {16'h0, rw_mem[slot(idx, COSDO_IDX_RW)], sub, idx,
                         COSDO_RD_ANS2}; // [R5] [R6] [R12]
        else if (in_block(idx, COSDO_IDX_RB))
          tx_data_nxt = {24'h0, rb_mem[slot(idx, COSDO_IDX_RB)], sub, idx,
                         COSDO_RD_ANS1}; // [R5] [R6]
        else if (in_block(idx, COSDO_IDX_WW))
          tx_data_nxt = {16'h0, ww_r[slot(idx, COSDO_IDX_WW)], sub, idx,
                         COSDO_RD_ANS2}; // [R5] [R6]
        else if (in_block(idx, COSDO_IDX_WB))
          tx_data_nxt = {24'h0, wb_r[slot(idx, COSDO_IDX_WB)], sub, idx,
                         COSDO_RD_ANS1}; // [R5] [R6]
        else if (idx == COSDO_IDX_PARAM) // [R1]
        begin
          if (sub == 8'h00)
            tx_data_nxt = {24'h0, COSDO_PARAM_N, sub, idx, COSDO_RD_ANS1};
          else if (sub == 8'h01)
            tx_data_nxt = {21'h0, rx_own, sub, idx, COSDO_RD_ANS4};
          else if (sub == 8'h02)
            tx_data_nxt = {21'h0, tx_own, sub, idx, COSDO_RD_ANS4};
          else
            tx_data_nxt = abort_t(idx, sub, COSDO_ABT_SUB); // [R19]
        end
        else if (idx == COSDO_IDX_SAVE && sub == 8'h00)
        begin
          // The save record is read in segments to exercise that path.
          tx_data_nxt  = {32'h8, sub, idx, COSDO_SEG_INIT}; // [R7] [R8]
          state_nxt    = COSDO_SEG;
          seg_left_nxt = 8'h08;
          seg_pos_nxt  = 8'h00;
          seg_tog_nxt  = 1'b0;
          seg_idx_nxt  = idx;
          seg_sub_nxt  = sub;
        end
      end
      else if ((cmd == COSDO_SEG_REQ0 || cmd == COSDO_SEG_REQ1) &&
               state_r == COSDO_SEG &&
               cmd[4] == seg_tog_r) // [R8]
      begin
        // Eight byte payload, index and sub-index twice, zero padded.
        // Every segment carries four bytes; the command byte holds only the toggle bit, no size code.
        seg_word    = {16'h0, seg_sub_r, seg_idx_r, seg_sub_r, seg_idx_r};
        tx_data_nxt = {24'h0, 32'(seg_word >> {seg_pos_r, 3'b000}), // [R12]
                       (seg_tog_r ? COSDO_TOGGLE_BIT : 8'h00)}; // [R8]
        if (seg_left_r <= 8'h04)
          state_nxt = COSDO_IDLE; // [R9]
        seg_left_nxt = seg_left_r - 8'h04;
        seg_pos_nxt  = seg_pos_r + 8'h04;
        seg_tog_nxt  = ~seg_tog_r;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < COSDO_MARKS; k++)
      begin
        ww_r[k] <= 16'h0000;
        wb_r[k] <= 8'h00;
        rw_mem[k] <= 16'h0000;
        rb_mem[k] <= 8'h00;
      end
      state_r    <= COSDO_IDLE;
      seg_left_r <= 8'h00;
      seg_pos_r  <= 8'h00;
      seg_tog_r  <= 1'b0;
      seg_idx_r  <= 16'h0000;
      seg_sub_r  <= 8'h00;
      tx_valid   <= 1'b0;
      tx_id      <= 11'h000;
      tx_data    <= 64'h0;
      nv_write   <= 1'b0;
      nv_save    <= 1'b0;
      nv_index   <= 16'h0000;
      nv_sub     <= 8'h00;
      nv_value   <= 32'h0;
      pdo_rx_accept <= 1'b0;
      pdo_tx_enable <= 1'b0;
      map_ok     <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < COSDO_MARKS; k++)
      begin
        ww_r[k] <= ww_nxt[k];
        wb_r[k] <= wb_nxt[k];
      end
      if (rmark_we && operational && !rmark_byte) // [R14] [R15]
        rw_mem[rmark_sel] <= rmark_value;
      if (rmark_we && operational && rmark_byte) // [R14] [R15]
        rb_mem[rmark_sel] <= rmark_value[7:0];
      state_r    <= state_nxt;
      seg_left_r <= seg_left_nxt;
      seg_pos_r  <= seg_pos_nxt;
      seg_tog_r  <= seg_tog_nxt;
      seg_idx_r  <= seg_idx_nxt;
      seg_sub_r  <= seg_sub_nxt;
      tx_valid   <= tx_valid_nxt;
      tx_id      <= tx_own; // [R2]
      tx_data    <= tx_data_nxt;
      nv_write   <= nv_write_nxt;
      nv_save    <= nv_save_nxt;
      nv_index   <= nv_index_nxt;
      nv_sub     <= nv_sub_nxt;
      nv_value   <= nv_value_nxt;
      pdo_rx_accept <= pdo_rx_valid && operational; // [R14]
      pdo_tx_enable <= operational; // [R14]
      // Only marker blocks in the vendor range may be mapped.
      map_ok <= map_tx ? in_block(map_index, COSDO_IDX_WW) || // [R16] [R17]
                         in_block(map_index, COSDO_IDX_WB)
                       : in_block(map_index, COSDO_IDX_RW) ||
                         in_block(map_index, COSDO_IDX_RB);
    end
  end

endmodule

// file: dv/cosdo_server_checker.sv
// Port assertions for the service-data server.
module cosdo_server_checker
  import cosdo_pkg::*;
#(
  parameter logic [6:0] NODE_ID = 7'h01
)
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Telegrams
  input wire logic        rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic [63:0] rx_data,
  input wire logic        tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [63:0] tx_data,
  // Store, process data and mapping
  input wire logic        nv_write,
  input wire logic [15:0] nv_index,
  input wire logic        operational,
  input wire logic        pdo_rx_valid,
  input wire logic        pdo_rx_accept,
  input wire logic        pdo_tx_enable,
  input wire logic [15:0] map_index,
  input wire logic        map_tx,
  input wire logic        map_ok
);
  logic own;
  logic [7:0] cmd;
  assign own = rx_valid && rx_id == COSDO_RX_BASE + {4'h0, NODE_ID};
  assign cmd = rx_data[7:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_answer; own && cmd != COSDO_ABORT |=> tx_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_silent; !own |=> !tx_valid; endproperty
  a_silent: assert property (p_silent) else $error("stray answer");
  property p_txid; tx_valid |-> tx_id == COSDO_TX_BASE + {4'h0, NODE_ID};
  endproperty
  a_txid: assert property (p_txid) else $error("bad tx id");
  property p_echo; own && !(cmd inside {8'h60, 8'h70, 8'h80})
    |=> tx_data[31:8] == $past(rx_data[31:8]); endproperty
  a_echo: assert property (p_echo) else $error("no echo");
  property p_wrack; own && cmd == COSDO_WR4 && rx_data[23:8] == COSDO_IDX_WW
    |=> tx_data[7:0] == COSDO_WR_ACK; endproperty
  a_wrack: assert property (p_wrack) else $error("bad ack");
  property p_pdorx; 1'b1 |=> pdo_rx_accept ==
    ($past(pdo_rx_valid) && $past(operational)); endproperty
  a_pdorx: assert property (p_pdorx) else $error("rx gate");
  property p_pdotx; 1'b1 |=> pdo_tx_enable == $past(operational); endproperty
  a_pdotx: assert property (p_pdotx) else $error("tx gate");
  property p_map; map_tx && map_index >= COSDO_IDX_WW &&
    map_index <= 16'h3d61 |=> map_ok; endproperty
  a_map: assert property (p_map) else $error("map refused");
  property p_nomap; !map_tx && (map_index < COSDO_IDX_RW ||
    map_index > 16'h3d21) |=> !map_ok; endproperty
  a_nomap: assert property (p_nomap) else $error("map allowed");
  property p_nv; nv_write |-> nv_index >= COSDO_IDX_NV && $past(own);
  endproperty
  a_nv: assert property (p_nv) else $error("bad store");
  cover property (own && cmd == COSDO_RD);
  cover property (tx_valid && tx_data[7:0] == COSDO_SEG_INIT);
  cover property (pdo_rx_accept);
endmodule

// file: dv/cosdo_client.sv
// Service-data client model that frames requests and catches answers.
module cosdo_client
(
  // Clock and request from the bench
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [10:0] go_id,
  input  wire logic [63:0] go_data,
  // Telegram towards the server
  output logic             rx_valid,
  output logic [10:0]      rx_id,
  output logic [63:0]      rx_data,
  // Answer from the server
  input  wire logic        tx_valid,
  input  wire logic [63:0] tx_data,
  output logic             seen,
  output logic [63:0]      resp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rx_valid = 1'b0;
    rx_id = 11'h0;
    rx_data = 64'h0;
    seen = 1'b0;
    resp = 64'h0;
  end
  // Idle id and data lines flip every cycle so a stale telegram is never reused.
  always @(posedge core_clk)
  begin
    rx_valid <= go;
    rx_id <= go ? go_id : ~rx_id;
    rx_data <= go ? go_data : ~rx_data;
    if (go)
      seen <= 1'b0;
    else if (tx_valid)
      seen <= 1'b1;
    if (tx_valid)
      resp <= tx_data;
  end
endmodule

// file: dv/tb_top.sv
// Self-checking testbench for the service-data server.
module tb_top
  import cosdo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] RXID = 11'h601;
  logic        core_clk, reset, go, rx_valid, tx_valid, seen, nv_write;
  logic        nv_save, operational, pdo_rx_valid, pdo_rx_accept, rmark_we;
  logic        pdo_tx_enable, rmark_byte, map_tx, map_ok;
  logic        saw_save = 1'b0;
  int          nv_cnt = 0;
  logic [10:0] go_id, rx_id, tx_id;
  logic [63:0] go_data, rx_data, tx_data, resp;
  logic [15:0] nv_index, rmark_value, map_index, cur_x;
  logic [31:0] nv_value;
  logic [7:0]  nv_sub, cur_s;
  logic [7:0]  wc [4] = '{COSDO_WR_UNSPEC, COSDO_WR4, COSDO_WR2, COSDO_WR1};
  logic [4:0]  rmark_sel;
  int          failures = 0;
  int          checked = 0;
  cosdo_client cl_u (.core_clk, .go, .go_id, .go_data, .rx_valid, .rx_id,
    .rx_data, .tx_valid, .tx_data, .seen, .resp);
  cosdo_server #(.NODE_ID(7'h01)) dut_u (.core_clk, .reset, .rx_valid,
    .rx_id, .rx_data, .tx_valid, .tx_id, .tx_data, .nv_write, .nv_save,
    .nv_index, .nv_sub, .nv_value, .operational, .pdo_rx_valid,
    .pdo_rx_accept, .pdo_tx_enable, .rmark_we, .rmark_byte, .rmark_sel,
    .rmark_value, .map_index, .map_tx, .map_ok);
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (nv_save)
      saw_save <= 1'b1;
    if (nv_write)
      nv_cnt <= nv_cnt + 1;
  end
  task chk(input logic [64:0] g, input logic [64:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task sdo(input logic [10:0] i, input logic [7:0] c, input logic [15:0] x,
    input logic [7:0] s, input logic [31:0] v);
    @(posedge core_clk);
    go <= 1'b1;
    go_id <= i;
    go_data <= {v, s, x, c};
    @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
    cur_x = x;
    cur_s = s;
  endtask
  task ans(input logic [7:0] c, input logic [31:0] v);
    chk({seen, resp}, {1'b1, v, cur_s, cur_x, c});
  endtask
  task t_param;
    for (int k = 0; k < 3; k++)
    begin
      sdo(RXID, COSDO_RD, COSDO_IDX_PARAM, 8'(k), 32'h0);
      if (k == 0)
        ans(COSDO_RD_ANS1, 32'h2);
      else
        ans(COSDO_RD_ANS4, k == 1 ? 32'h601 : 32'h581);
    end
    sdo(RXID, COSDO_WR4, COSDO_IDX_PARAM, 8'h01, 32'h0);
    ans(COSDO_ABORT, COSDO_ABT_RO);
  endtask
  task t_write;
    for (int k = 0; k < 4; k++)
    begin
      sdo(RXID, wc[k], COSDO_IDX_WW, 8'h00, 32'h0000_00a5);
      ans(COSDO_WR_ACK, 32'h0);
    end
    sdo(RXID, COSDO_WR2, COSDO_IDX_WW, 8'h00, 32'h1234);
    ans(COSDO_WR_ACK, 32'h0);
    sdo(RXID, COSDO_RD, COSDO_IDX_WW, 8'h00, 32'h0);
    ans(COSDO_RD_ANS2, 32'h1234);
    sdo(RXID, COSDO_WR1, 16'h3d61, 8'h00, 32'h5a);
    sdo(RXID, COSDO_RD, 16'h3d61, 8'h00, 32'h0);
    ans(COSDO_RD_ANS1, 32'h5a);
  endtask
  task t_err;
    sdo(RXID, COSDO_WR2, COSDO_IDX_RB, 8'h00, 32'h1);
    ans(COSDO_ABORT, COSDO_ABT_RO);
    sdo(RXID, COSDO_RD, 16'h0001, 8'h00, 32'h0);
    ans(COSDO_ABORT, COSDO_ABT_NOOBJ);
    sdo(RXID, 8'h55, COSDO_IDX_WW, 8'h00, 32'h0);
    ans(COSDO_ABORT, COSDO_ABT_CMD);
  endtask
  task t_seg;
    sdo(RXID, COSDO_RD, COSDO_IDX_SAVE, 8'h00, 32'h0);
    ans(COSDO_SEG_INIT, 32'h8);
    sdo(RXID, COSDO_SEG_REQ0, 16'h0, 8'h00, 32'h0);
    chk({seen, resp}, {1'b1, 24'h0, 32'h1000_1010, 8'h00});
    sdo(RXID, COSDO_SEG_REQ1, 16'h0, 8'h00, 32'h0);
    chk({seen, resp}, {1'b1, 24'h0, 32'h10, COSDO_TOGGLE_BIT});
    sdo(RXID, COSDO_SEG_REQ0, 16'h0, 8'h00, 32'h0);
    ans(COSDO_ABORT, COSDO_ABT_CMD);
  endtask
  task t_route;
    sdo(11'h602, COSDO_RD, COSDO_IDX_PARAM, 8'h00, 32'h0);
    chk(65'(seen), 65'h0);
    sdo(RXID, COSDO_ABORT, COSDO_IDX_WW, 8'h00, 32'h0);
    chk(65'(seen), 65'h0);
  endtask
  task t_nv;
    int n0;
    n0 = nv_cnt;
    sdo(RXID, COSDO_WR4, 16'h2100, 8'h03, 32'hcafe_0001);
    ans(COSDO_WR_ACK, 32'h0);
    chk({nv_index, nv_sub, nv_value}, 65'h2100_03_cafe0001);
    chk(65'(nv_cnt - n0), 65'h1);
    sdo(RXID, COSDO_WR4, COSDO_IDX_SAVE, 8'h01, 32'h6576_6173);
    ans(COSDO_WR_ACK, 32'h0);
    chk(65'(saw_save), 65'h1);
    chk(65'(nv_cnt - n0), 65'h1);
  endtask
  task t_pdo;
    @(posedge core_clk);
    pdo_rx_valid <= 1'b1;
    map_tx <= 1'b1;
    map_index <= COSDO_IDX_WW;
    rmark_we <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({pdo_rx_accept, pdo_tx_enable, map_ok}, 65'h1);
    sdo(RXID, COSDO_RD, 16'h3ce5, 8'h00, 32'h0);
    ans(COSDO_RD_ANS2, 32'h0);
    operational <= 1'b1;
    map_index <= COSDO_IDX_RW;
    repeat (2) @(posedge core_clk);
    chk({pdo_rx_accept, pdo_tx_enable, map_ok}, 65'h6);
    map_tx <= 1'b0;
    rmark_byte <= 1'b1;
    @(posedge core_clk);
    rmark_we <= 1'b0;
    sdo(RXID, COSDO_RD, 16'h3ce5, 8'h00, 32'h0);
    ans(COSDO_RD_ANS2, 32'habcd);
    sdo(RXID, COSDO_RD, 16'h3d05, 8'h00, 32'h0);
    ans(COSDO_RD_ANS1, 32'hcd);
    chk(65'(map_ok), 65'h1);
    map_index <= COSDO_IDX_SAVE;
    repeat (2) @(posedge core_clk);
    chk(65'(map_ok), 65'h0);
  endtask
  task results;
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {core_clk, go, go_id, go_data, operational, pdo_rx_valid} = '0;
    {rmark_we, rmark_byte, map_tx, map_index} = '0;
    {rmark_sel, rmark_value} = {5'd3, 16'habcd};
    reset = 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_param;
    t_write;
    t_err;
    t_seg;
    t_route;
    t_nv;
    t_pdo;
    results;
  end
  // Whole run needs under two hundred cycles; requests wait a fixed three cycles, so a missing answer fails a check, not this limit.
  initial
  begin
    repeat (3000) @(posedge core_clk);
    failures++;
    results;
  end
endmodule
bind cosdo_server cosdo_server_checker #(.NODE_ID(NODE_ID)) chk_u (
  .core_clk, .reset, .rx_valid, .rx_id, .rx_data, .tx_valid, .tx_id,
  .tx_data, .nv_write, .nv_index, .operational, .pdo_rx_valid,
  .pdo_rx_accept, .pdo_tx_enable, .map_index, .map_tx, .map_ok);
